// ### rtl/servo_param_defines.vh
// Constants for the servo parameter store: offsets, reset values, codes and limits
`ifndef SERVO_PARAM_DEFINES_VH
`define SERVO_PARAM_DEFINES_VH

// ****************************************************************
// Address map (byte offsets)
// ****************************************************************
`define GRP_BASIC_BASE  12'h000
`define GRP_GAIN_BASE   12'h100
`define GRP_EXT_BASE    12'h200
`define GRP_IO_BASE     12'h300
`define CTRL_OFFSET     12'h400
`define STATION_OFFSET  12'h404
`define STATUS_OFFSET   12'h408
`define GEAR_ERR_OFFSET 12'h40C

// ****************************************************************
// Basic group entry indices (entry n sits at base + 4*index)
// ****************************************************************
`define IDX_CTRL_MODE   5'd0
`define IDX_REGEN       5'd1
`define IDX_ABS_EN      5'd2
`define IDX_UNUSED_A    5'd3
`define IDX_RSVD_B      5'd4
`define IDX_GEAR_MACH   5'd5
`define IDX_GEAR_MOTOR  5'd6
`define IDX_TUNE_MODE   5'd7
`define IDX_TUNE_RESP   5'd8
`define IDX_SETTLE_WIN  5'd9
`define IDX_FWD_TORQUE  5'd10
`define IDX_REV_TORQUE  5'd11
`define IDX_MAKER_C     5'd12
`define IDX_ROT_DIR     5'd13
`define IDX_ENC_PULSES  5'd14
`define IDX_MAKER_D     5'd15
`define IDX_MAKER_E     5'd16
`define IDX_MAKER_F     5'd17
`define IDX_GUARD       5'd18
`define BASIC_COUNT     19

// Entries that only take effect after a power cycle
`define POWER_CYCLE_MASK 19'h4E067
// Manufacturer-reserved entries: read back factory value, writes ignored
`define RESERVED_MASK    19'h39018

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_ZERO        16'h0000
`define RST_GEAR        16'h0001
`define RST_TUNE_MODE   16'h0001
`define RST_TUNE_RESP   16'h000C
`define RST_SETTLE_WIN  16'h0064
`define RST_TORQUE      16'h03E8
`define RST_MAKER_C     16'h0002
`define RST_ENC_PULSES  16'h0FA0
`define RST_GUARD       16'h000C
`define RST_STATION     16'h0001

// ****************************************************************
// Group access guard codes
// ****************************************************************
`define GUARD_BASIC_ONLY 16'h0000
`define GUARD_NO_IO      16'h000B
`define GUARD_ALL        16'h000C
`define GUARD_RO_BASIC   16'h100B
`define GUARD_RO_ALL     16'h100C

// ****************************************************************
// Limits
// ****************************************************************
`define GEAR_MIN        16'h0001
`define GEAR_MAX        16'h4000
`define RATIO_LIMIT     32'h0000270F
`define STATION_PRODUCT 32'h00007FFF
`define GEAR_PRODUCT    32'h000186A0
`define ABS_ENABLE_CODE 4'h1
`define CTRL_COMMIT_BIT 0

`endif

// ### rtl/servo_parameter_store_write_guard.v
// Servo parameter store with group access guard, gear checks and gear scaling
//
// Functional notes
// - power-cycle parameters keep old active value until a power-cycle commit.
// - guard 000Ch lets all four groups be read and written.
// - guard 0000h lets only the basic group be read and written.
// - guard 000Bh allows basic, gain and extension groups; I/O group blocked.
// - 100Bh reads basic only, 100Ch reads all; only guard entry and own registers writable.
// - both gear counts accept writes from 1 to 16384 only.
// - parameter error on bad gear ratio, station product or gear product.
// - parameter error when regenerative option selection is not valid.
// - absolute position function stays off unless its parameter enables it.
// - machine movement scaled to motor rotation by machine over motor gear count.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "servo_param_defines.vh"

module servo_parameter_store_write_guard #(
  parameter        GROUP_DEPTH      = 16,
  parameter [15:0] REGEN_VALID_MASK = 16'h00FF
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Machine-side movement in, motor-side movement out
  input  wire        cmd_valid,
  input  wire [15:0] cmd_delta,
  output wire        cmd_ready,
  output reg         motor_valid,
  output reg  [31:0] motor_delta,
  // Status
  output reg         parameter_error_alarm,
  output reg         absolute_position_enable
);

  // ****************************************************************
  // Basic group storage: written value and value in use
  // ****************************************************************
  wire [16*`BASIC_COUNT-1:0] sto_flat;
  wire [16*`BASIC_COUNT-1:0] act_flat;
  reg                        commit_q;
  wire                       apb_setup;
  wire                       apb_access;
  wire                       wr_basic_hit;
  wire [4:0]                 wr_basic_idx;
  wire                       wr_allowed;

  function [15:0] basic_reset;
    input [4:0] idx;
    begin
      case (idx)
        `IDX_GEAR_MACH:  basic_reset = `RST_GEAR;
        `IDX_GEAR_MOTOR: basic_reset = `RST_GEAR;
        `IDX_TUNE_MODE:  basic_reset = `RST_TUNE_MODE;
        `IDX_TUNE_RESP:  basic_reset = `RST_TUNE_RESP;
        `IDX_SETTLE_WIN: basic_reset = `RST_SETTLE_WIN;
        `IDX_FWD_TORQUE: basic_reset = `RST_TORQUE;
        `IDX_REV_TORQUE: basic_reset = `RST_TORQUE;
        `IDX_MAKER_C:    basic_reset = `RST_MAKER_C;
        `IDX_ENC_PULSES: basic_reset = `RST_ENC_PULSES;
        `IDX_GUARD:      basic_reset = `RST_GUARD;
        default:         basic_reset = `RST_ZERO;
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `BASIC_COUNT; gi = gi + 1)
    begin : g_basic
      localparam [4:0]  IDX   = gi;
      localparam        DELAY = (`POWER_CYCLE_MASK >> gi) & 1;
      localparam        RSVD  = (`RESERVED_MASK >> gi) & 1;
      localparam [15:0] RST   = basic_reset(IDX);
      reg [15:0] sto_q;
      reg [15:0] act_q;

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sto_q <= RST;
        end
        else if (wr_allowed && wr_basic_hit && wr_basic_idx == IDX && RSVD == 0)
        begin
          sto_q <= pwdata[15:0];
        end
      end

      // Delayed entries only follow the written value at a power-cycle commit
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          act_q <= RST;
        end
        else if (DELAY == 0 || commit_q)
        begin
          act_q <= sto_q;
        end
      end

      assign sto_flat[16*gi +: 16] = sto_q;
      assign act_flat[16*gi +: 16] = act_q;
    end
  endgenerate

  wire [15:0] guard_act   = act_flat[16*`IDX_GUARD +: 16];
  wire [15:0] gear_mach   = act_flat[16*`IDX_GEAR_MACH +: 16];
  wire [15:0] gear_motor  = act_flat[16*`IDX_GEAR_MOTOR +: 16];
  wire [15:0] regen_sel   = act_flat[16*`IDX_REGEN +: 16];
  wire [15:0] abs_sel     = act_flat[16*`IDX_ABS_EN +: 16];

  // ****************************************************************
  // Group permissions from the guard code in use
  // ****************************************************************
  reg [3:0] rd_perm;
  reg [3:0] wr_perm;
  reg       guard_only;

  // Unknown codes fall back to the most restrictive reading set
  always @*
  begin
    rd_perm    = 4'h1;
    wr_perm    = 4'h0;
    guard_only = 1'b1;
    case (guard_act)
      `GUARD_BASIC_ONLY:
      begin
        rd_perm    = 4'h1;
        wr_perm    = 4'h1;
        guard_only = 1'b0;
      end
      `GUARD_NO_IO:
      begin
        rd_perm    = 4'h7;
        wr_perm    = 4'h7;
        guard_only = 1'b0;
      end
      `GUARD_ALL:
      begin
        rd_perm    = 4'hF;
        wr_perm    = 4'hF;
        guard_only = 1'b0;
      end
      `GUARD_RO_BASIC:
      begin
        rd_perm    = 4'h1;
        wr_perm    = 4'h0;
        guard_only = 1'b1;
      end
      `GUARD_RO_ALL:
      begin
        rd_perm    = 4'hF;
        wr_perm    = 4'h0;
        guard_only = 1'b1;
      end
      default:
      begin
        rd_perm    = 4'h1;
        wr_perm    = 4'h0;
        guard_only = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  localparam integer MEM_WORDS = 3 * GROUP_DEPTH;

  wire [1:0] grp       = paddr[9:8];
  wire [5:0] ent       = paddr[7:2];
  wire       in_group  = (paddr[11:10] == 2'b00);
  wire       in_own    = ((paddr & 12'hFF0) == `CTRL_OFFSET);
  wire       basic_ok  = in_group && grp == 2'd0 && ent < `BASIC_COUNT;
  wire       ext_ok    = in_group && grp != 2'd0 && ent < GROUP_DEPTH;
  wire       grp_map   = basic_ok || ext_ok;
  wire       guard_hit = basic_ok && ent[4:0] == `IDX_GUARD;
  wire       gear_hit  = basic_ok &&
                         (ent[4:0] == `IDX_GEAR_MACH || ent[4:0] == `IDX_GEAR_MOTOR);
  wire       gear_val  = pwdata[31:16] == 16'h0000 &&
                         pwdata[15:0] >= `GEAR_MIN && pwdata[15:0] <= `GEAR_MAX;
  wire       wr_perm_g = wr_perm[grp] || (guard_only && guard_hit);
  wire       wr_reject = !(grp_map || in_own) || (grp_map && !wr_perm_g) ||
                         (gear_hit && !gear_val);
  wire       rd_reject = !(grp_map || in_own) || (grp_map && !rd_perm[grp]);
  wire [5:0] mem_idx   = (grp - 2'd1) * GROUP_DEPTH[5:0] + ent;

  assign pready       = 1'b1;
  assign apb_setup    = psel && !penable;
  assign apb_access   = psel && penable;
  assign wr_allowed   = apb_access && pwrite && !wr_reject;
  assign wr_basic_hit = basic_ok;
  assign wr_basic_idx = ent[4:0];

  // ****************************************************************
  // Other groups and own control registers
  // ****************************************************************
  reg [15:0] ext_mem [0:MEM_WORDS-1];
  reg [15:0] station_q;
  integer    k;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (k = 0; k < MEM_WORDS; k = k + 1)
        ext_mem[k] <= 16'h0000;
    end
    else if (wr_allowed && ext_ok)
    begin
      ext_mem[mem_idx] <= pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      station_q <= `RST_STATION;
      commit_q  <= 1'b0;
    end
    else
    begin
      commit_q <= wr_allowed && in_own && paddr == `CTRL_OFFSET &&
                  pwdata[`CTRL_COMMIT_BIT];
      if (wr_allowed && paddr == `STATION_OFFSET)
        station_q <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  wire [31:0] mach32      = {16'h0000, gear_mach};
  wire [31:0] motor32     = {16'h0000, gear_motor};
  wire [31:0] ratio_hi    = motor32 * `RATIO_LIMIT;
  wire [31:0] ratio_lo    = mach32 * `RATIO_LIMIT;
  wire [31:0] station_pr  = motor32 * {16'h0000, station_q};
  wire [31:0] gear_pr     = mach32 * motor32;
  wire [2:0]  gear_err;
  wire        regen_bad;

  assign gear_err[0] = (mach32 > ratio_hi) || (ratio_lo < motor32);
  assign gear_err[1] = station_pr > `STATION_PRODUCT;
  assign gear_err[2] = gear_pr > `GEAR_PRODUCT;
  assign regen_bad   = (regen_sel[15:4] != 12'h000) ||
                       !REGEN_VALID_MASK[regen_sel[3:0]];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parameter_error_alarm    <= 1'b0;
      absolute_position_enable <= 1'b0;
    end
    else
    begin
      parameter_error_alarm    <= (|gear_err) || regen_bad;
      absolute_position_enable <= abs_sel[15:4] == 12'h000 &&
                                  abs_sel[3:0] == `ABS_ENABLE_CODE;
    end
  end

  // ****************************************************************
  // Read path: data captured in the setup cycle, zero wait states
  // ****************************************************************
  reg [31:0] rd_word;

  always @*
  begin
    rd_word = 32'h00000000;
    if (basic_ok)
      rd_word = {16'h0000, sto_flat[16*ent[4:0] +: 16]};
    else if (ext_ok)
      rd_word = {16'h0000, ext_mem[mem_idx]};
    else if (paddr == `STATION_OFFSET)
      rd_word = {16'h0000, station_q};
    else if (paddr == `STATUS_OFFSET)
      rd_word = {guard_act, 14'h0000, absolute_position_enable, parameter_error_alarm};
    else if (paddr == `GEAR_ERR_OFFSET)
      rd_word = {28'h0000000, regen_bad, gear_err};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata  <= (pwrite || rd_reject) ? 32'h00000000 : rd_word;
      pslverr <= pwrite ? wr_reject : rd_reject;
    end
  end

  // ****************************************************************
  // Gear scaling: product by machine count, serial divide by motor count
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DIV  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [2:0]  state_q;
  reg  [31:0] quo_q;
  reg  [16:0] rem_q;
  reg  [15:0] den_q;
  reg  [5:0]  cnt_q;
  wire [16:0] rem_sh = {rem_q[15:0], quo_q[31]};
  wire        fits   = rem_sh >= {1'b0, den_q};

  // Divisor latched at start so a commit mid-divide cannot skew the result
  assign cmd_ready = state_q == ST_IDLE;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= ST_IDLE;
      quo_q       <= 32'h00000000;
      rem_q       <= 17'h00000;
      den_q       <= 16'h0001;
      cnt_q       <= 6'h00;
      motor_valid <= 1'b0;
      motor_delta <= 32'h00000000;
    end
    else
    begin
      motor_valid <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_valid)
          begin
            quo_q   <= {16'h0000, cmd_delta} * mach32;
            rem_q   <= 17'h00000;
            den_q   <= gear_motor;
            cnt_q   <= 6'h20;
            state_q <= ST_DIV;
          end
        end
        ST_DIV:
        begin
          quo_q <= {quo_q[30:0], fits};
          rem_q <= fits ? rem_sh - {1'b0, den_q} : rem_sh;
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01)
            state_q <= ST_DONE;
        end
        ST_DONE:
        begin
          motor_delta <= quo_q;
          motor_valid <= 1'b1;
          state_q     <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### sim/servo_store_chk_asserts.sv
// Port-level assertions for the servo parameter store
`timescale 1ns/1ps

module servo_store_chk (
  // APB slave side
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Scaling and status
  input wire        cmd_valid,
  input wire [15:0] cmd_delta,
  input wire        cmd_ready,
  input wire        motor_valid,
  input wire [31:0] motor_delta,
  input wire        parameter_error_alarm,
  input wire        absolute_position_enable
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire setup  = psel && !penable;
  wire take   = cmd_valid && cmd_ready;
  wire commit = psel && penable && pwrite && paddr == 12'h400 && pwdata[0];
  // Station count is live, so its write moves the checks without a commit
  wire stn_wr = psel && penable && pwrite && paddr == 12'h404;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_scale_latency: assert property (take |-> ##34 motor_valid)
    else $error("scaled result late or missing");
  a_busy_after_take: assert property (take |=> !cmd_ready [*8])
    else $error("scaler took a request while busy");
  a_result_pulse: assert property (motor_valid |=> !motor_valid)
    else $error("result strobe longer than one cycle");
  a_gear_zero_err: assert property (
    setup && pwrite && paddr == 12'h014 && pwdata == 32'h0 |=> pslverr)
    else $error("zero gear count accepted");
  a_gear_big_err: assert property (
    setup && pwrite && paddr == 12'h018 && pwdata == 32'h4001 |=> pslverr)
    else $error("oversized gear count accepted");
  a_unmapped_err: assert property (
    setup && paddr == 12'h410 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // Commit pulse, then active value, then status flop: outputs move three edges on
  a_abs_on_commit: assert property (
    $rose(absolute_position_enable) |-> $past(commit, 3))
    else $error("absolute function enabled without a commit");
  a_alarm_on_commit: assert property (
    $changed(parameter_error_alarm) |-> $past(commit, 3) || $past(stn_wr, 2))
    else $error("parameter error moved without a commit");

  c_take: cover property (take);
  c_commit: cover property (commit);
  c_refused: cover property (psel && penable && pslverr);
endmodule

bind servo_parameter_store_write_guard servo_store_chk i_servo_store_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .cmd_valid(cmd_valid), .cmd_delta(cmd_delta), .cmd_ready(cmd_ready),
  .motor_valid(motor_valid), .motor_delta(motor_delta),
  .parameter_error_alarm(parameter_error_alarm),
  .absolute_position_enable(absolute_position_enable)
);

// ### sim/servo_parameter_store_write_guard_bench.sv
// Self-checking bench for the servo parameter store
`timescale 1ns/1ps

module servo_parameter_store_write_guard_bench;
  reg          pclk, presetn, psel, penable, pwrite, cmd_valid;
  reg   [11:0] paddr;
  reg   [31:0] pwdata;
  reg   [15:0] cmd_delta;
  wire         pready, pslverr, cmd_ready, motor_valid, alarm, abs_en;
  wire  [31:0] prdata, motor_delta;
  integer      n_errors, total_checks;

  servo_parameter_store_write_guard i_servo_parameter_store_write_guard (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_delta(cmd_delta), .cmd_ready(cmd_ready),
    .motor_valid(motor_valid), .motor_delta(motor_delta),
    .parameter_error_alarm(alarm), .absolute_position_enable(abs_en)
  );

  always #12.5 pclk = ~pclk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; for a read d is the expected data, e the expected error
  task xf(input w, input [11:0] a, input [31:0] d, input e);
    integer i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i = i + 1;
    end
    while (pready !== 1'b1 && i < 20);
    if (i == 20)
    begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
    check({31'h0, pslverr}, {31'h0, e});
    if (!w)
      check(prdata, e ? 32'h0 : d);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Power-cycle commit; active values move one edge after the write, status flops one later
  task commit;
    xf(1'b1, 12'h400, 32'h1, 1'b0);
    repeat (3) @(posedge pclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    integer k;
    reg [303:0] rv;
    rv = {64'h000C_0000_0000_0000, 80'h0FA0_0000_0002_03E8_03E8,
          80'h0064_000C_0001_0001_0001, 80'h0000_0000_0000_0000_0000};
    for (k = 0; k < 19; k = k + 1)
      xf(1'b0, 12'(k * 4), {16'h0, rv[k*16 +: 16]}, 1'b0);
    xf(1'b0, 12'h408, 32'h000C_0000, 1'b0);
  endtask

  task t_guard;
    integer j, g;
    reg [79:0] codes;
    reg [19:0] rm, wm;
    reg [15:0] sv [0:3];
    reg [15:0] prev, v;
    reg [11:0] ga;
    codes = 80'h000C_0000_000B_100B_100C;
    rm = 20'hF8E8F;
    wm = 20'hF8E00;
    prev = 16'h000C;
    for (j = 4; j >= 0; j = j - 1)
    begin
      xf(1'b1, 12'h048, {16'h0, codes[j*16 +: 16]}, 1'b0);
      xf(1'b0, 12'h408, {prev, 16'h0}, 1'b0);
      commit;
      xf(1'b0, 12'h408, {codes[j*16 +: 16], 16'h0}, 1'b0);
      prev = codes[j*16 +: 16];
      for (g = 3; g >= 0; g = g - 1)
      begin
        ga = (g == 3) ? 12'h01C : 12'h300 - 12'(g * 256);
        v = {8'hA5, 4'(j), 4'(g)};
        if (wm[j*4 + g])
          sv[g] = v;
        xf(1'b1, ga, {16'h0, v}, !wm[j*4 + g]);
        xf(1'b0, ga, {16'h0, sv[g]}, !rm[j*4 + g]);
      end
    end
    xf(1'b1, 12'h048, 32'h000C, 1'b0);
    commit;
    xf(1'b0, 12'h410, 32'h0, 1'b1);
    xf(1'b1, 12'h410, 32'h1234, 1'b1);
  endtask

  task t_abs;
    xf(1'b1, 12'h008, 32'h1, 1'b0);
    check({31'h0, abs_en}, 32'h0);
    xf(1'b0, 12'h008, 32'h1, 1'b0);
    commit;
    check({31'h0, abs_en}, 32'h1);
    xf(1'b1, 12'h008, 32'h2, 1'b0);
    commit;
    check({31'h0, abs_en}, 32'h0);
  endtask

  task t_gear;
    integer k;
    reg [383:0] tb;
    reg [63:0] e;
    tb = {256'h4000_0001_0001_0001_0190_012C_006E_0006_0001_2710_0001_0001_0001_270F_0001_0000,
          128'h270F_0001_0001_0000_0032_0014_0001_0000};
    xf(1'b1, 12'h014, 32'h0, 1'b1);
    xf(1'b1, 12'h018, 32'h4001, 1'b1);
    xf(1'b1, 12'h018, 32'h1_0001, 1'b1);
    for (k = 5; k >= 0; k = k - 1)
    begin
      e = tb[k*64 +: 64];
      xf(1'b1, 12'h014, {16'h0, e[63:48]}, 1'b0);
      xf(1'b1, 12'h018, {16'h0, e[47:32]}, 1'b0);
      xf(1'b1, 12'h404, {16'h0, e[31:16]}, 1'b0);
      commit;
      xf(1'b0, 12'h40C, {16'h0, e[15:0]}, 1'b0);
      check({31'h0, alarm}, {31'h0, e[15:0] != 16'h0});
    end
  endtask

  task t_regen;
    xf(1'b1, 12'h004, 32'h0100, 1'b0);
    commit;
    check({31'h0, alarm}, 32'h1);
    xf(1'b0, 12'h40C, 32'h8, 1'b0);
    xf(1'b1, 12'h004, 32'h0003, 1'b0);
    commit;
    check({31'h0, alarm}, 32'h0);
    // The bench never writes maker entries, so the factory value must still stand
    xf(1'b0, 12'h030, 32'h0002, 1'b0);
  endtask

  // Gear is 50 over 20 here; the second request follows the first result at once
  task t_scale;
    integer k, n;
    @(posedge pclk);
    for (k = 0; k < 2; k = k + 1)
    begin
      cmd_valid <= 1'b1;
      cmd_delta <= k ? 16'hFFFF : 16'h0007;
      @(posedge pclk);
      check({31'h0, cmd_ready}, 32'h1);
      cmd_valid <= 1'b0;
      n = 0;
      do
      begin
        @(posedge pclk);
        n = n + 1;
      end
      while (motor_valid !== 1'b1 && n < 100);
      if (n == 100)
      begin
        n_errors = n_errors + 1;
        tally_and_finish;
      end
      check(n, 34);
      check(motor_delta, k ? 32'h0002_7FFD : 32'h0000_0011);
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cmd_valid = 1'b0;
    cmd_delta = 16'h0;
    n_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_guard;
    t_abs;
    t_gear;
    t_regen;
    t_scale;
    tally_and_finish;
  end
endmodule
